// *** logic/dcf_pkg.sv ***
// Constants shared by the 18-bit dual-clock FIFO and its storage array.
// Assumes an APB master in the write-clock domain and synchronous strap pins.
//
// Functional notes
// [R1] Words are 18 bits; depth is 256, 512, 1K or 4K, set at build time.
// [R2] Separate 18-bit input and output ports, each with own clock and enable.
// [R3] Each write-clock edge with write enable active stores the input word.
// [R4] Each read-clock edge with read enable active delivers the next stored word.
// [R5] Correct with one shared clock or two independent asynchronous clocks.
// [R6] Simultaneous reads and writes never corrupt data or pointers.
// [R7] Empty flag is set and cleared only on read-clock edges.
// [R8] Full flag is set and cleared only on write-clock edges.
// [R9] Empty and full outputs are registered and glitch-free.
// [R10] With sync-mode strap low, almost flags are registered in their own domains.
// [R11] Five status outputs encode empty, almost empty, half, almost full, full.
// [R12] Half-full shares its pin with write-chain output; valid when not cascaded.
// [R13] When cascaded, the shared pin carries the write-chain handoff to the next buffer.
// [R14] System wires chain outputs to next buffer's inputs and closes the ring.
// [R15] First-in-chain strap is low on the first buffer, high on the others.
// [R16] Write with enable low stores only when not full; ignored when full.
// [R17] Read with enable low delivers only when not empty; ignored when empty.
// [R18] Empty output is active low while no words are held.
// [R19] Full output is active low while every entry is occupied.
// [R20] Half output goes low while stored words exceed half the depth.
// [R21] Output enable inactive drives read data outputs to a defined idle value.

package dcf_pkg;

    // ==========================================================
    // Data path
    localparam int DATA_W            = 18;
    localparam int DEPTH_DEFAULT     = 256;
    localparam int AE_OFFSET_DEFAULT = 8;
    localparam int AF_OFFSET_DEFAULT = 8;
    localparam logic [DATA_W-1:0] OUT_IDLE = 18'h00000;

    // ==========================================================
    // APB register map
    localparam int APB_ADDR_W = 8;
    localparam int APB_DATA_W = 32;
    localparam logic [APB_ADDR_W-1:0] REG_CTRL_ADDR   = 8'h00;
    localparam logic [APB_ADDR_W-1:0] REG_STATUS_ADDR = 8'h04;

    // CTRL fields
    localparam int CTRL_CASCADE_BIT = 0;

    // STATUS fields, all write-domain state
    localparam int STAT_FULL_N_BIT  = 0;
    localparam int STAT_SHARED_BIT  = 1;
    localparam int STAT_AFULL_N_BIT = 2;
    localparam int STAT_TOKEN_BIT   = 3;
    localparam int STAT_COUNT_LSB   = 16;

endpackage

// *** logic/dcf_mem_if.sv ***
// Storage-array access bundle between the FIFO control and its memory.
// Assumes write side fields are on the write clock, read side on the read clock.
`timescale 1ns/1ns

interface dcf_mem_if #(
    parameter int AW = 8,
    parameter int DW = 18
);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic          rd_en;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;

    modport ctrl  (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input  rd_data);
    modport store (input  wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

// *** logic/dcf_mem.sv ***
// Two-port storage array for the dual-clock FIFO.
// Assumes the controller never reads an entry in the cycle it is written.
`timescale 1ns/1ns

module dcf_mem #(
    parameter int AW = 8,
    parameter int DW = 18
) (
    input wire logic    i_wr_clk,
    input wire logic    i_rd_clk,
    dcf_mem_if.store    m
);
    logic [DW-1:0] mem_reg [2**AW];
    logic [DW-1:0] rd_data_reg;

    always_ff @(posedge i_wr_clk) begin
        if (m.wr_en) begin
            mem_reg[m.wr_addr] <= m.wr_data; // R3
        end
    end

    // Read port holds its last word between reads
    always_ff @(posedge i_rd_clk) begin
        if (m.rd_en) begin
            rd_data_reg <= mem_reg[m.rd_addr]; // R4
        end
    end

    assign m.rd_data = rd_data_reg;
endmodule

// *** logic/dcf_fifo.sv ***
// Dual-clock 18-bit FIFO with level flags, depth-cascade handoff and APB control.
// Assumes I_CLK is the write clock, I_RD_CLK the read clock, and straps static.
`timescale 1ns/1ns

module dcf_fifo #(
    parameter int DEPTH     = dcf_pkg::DEPTH_DEFAULT,
    parameter int AE_OFFSET = dcf_pkg::AE_OFFSET_DEFAULT,
    parameter int AF_OFFSET = dcf_pkg::AF_OFFSET_DEFAULT
) (
    input  wire logic                            I_CLK,
    input  wire logic                            I_RST,
    input  wire logic                            I_RD_CLK,
    input  wire logic                            I_WR_EN_N,
    input  wire logic [dcf_pkg::DATA_W-1:0]      I_DATA,
    input  wire logic                            I_RD_EN_N,
    input  wire logic                            I_OUT_EN_N,
    input  wire logic                            I_SYNC_FLAG_SEL_N,
    input  wire logic                            I_FIRST_IN_CHAIN_N,
    input  wire logic                            I_WR_CHAIN_IN_N,
    input  wire logic                            I_RD_CHAIN_IN_N,
    input  wire logic                            I_PSEL,
    input  wire logic                            I_PENABLE,
    input  wire logic                            I_PWRITE,
    input  wire logic [dcf_pkg::APB_ADDR_W-1:0]  I_PADDR,
    input  wire logic [dcf_pkg::APB_DATA_W-1:0]  I_PWDATA,
    output logic      [dcf_pkg::DATA_W-1:0]      O_DATA,
    output logic                                 O_EMPTY_N,
    output logic                                 O_FULL_N,
    output logic                                 O_ALMOST_EMPTY_N,
    output logic                                 O_ALMOST_FULL_N,
    output logic                                 O_HALF_WR_CHAIN_N,
    output logic                                 O_RD_CHAIN_OUT_N,
    output logic      [dcf_pkg::APB_DATA_W-1:0]  O_PRDATA,
    output logic                                 O_PREADY,
    output logic                                 O_PSLVERR
);
    localparam int AW    = $clog2(DEPTH); // R1
    localparam int PTR_W = AW + 1;
    localparam logic [PTR_W-1:0] HALF_LVL = PTR_W'(DEPTH / 2);
    localparam logic [PTR_W-1:0] AF_LVL   = PTR_W'(DEPTH - AF_OFFSET);
    localparam logic [PTR_W-1:0] AE_LVL   = PTR_W'(AE_OFFSET);

    // ==========================================================
    // Pointer helpers
    function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] to_bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = '0;
        b[PTR_W-1] = g[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic reg_hit(input logic [dcf_pkg::APB_ADDR_W-1:0] a);
        return (a == dcf_pkg::REG_CTRL_ADDR) || (a == dcf_pkg::REG_STATUS_ADDR);
    endfunction

    // ==========================================================
    // Declarations
    logic                       cascade_reg;
    logic                       pready_reg;
    logic                       pslverr_reg;
    logic [dcf_pkg::APB_DATA_W-1:0] prdata_reg;
    logic [dcf_pkg::APB_DATA_W-1:0] rd_word;
    logic [PTR_W-1:0]           wr_bin_reg, wr_bin_next, wr_gray_reg, wr_gray_next;
    logic [PTR_W-1:0]           rd_bin_reg, rd_bin_next, rd_gray_reg, rd_gray_next;
    logic [PTR_W-1:0]           rgs_meta_reg, rgs_reg, wgs_meta_reg, wgs_reg;
    logic [PTR_W-1:0]           count_w_reg, count_w_next, count_r_reg, count_r_next;
    logic [PTR_W-1:0]           af_count, ae_count;
    logic                       full_n_reg, full_next, wr_token_reg, wr_fire, do_write;
    logic                       empty_n_reg, empty_next, rd_token_reg, rd_fire, do_read;
    logic                       shared_reg, afull_n_reg, aempty_n_reg, rd_chain_reg;
    logic                       rst_meta_reg, rst_rd_reg, casc_meta_reg, casc_rd_reg;
    logic [dcf_pkg::DATA_W-1:0] data_out_reg;

    dcf_mem_if #(.AW(AW), .DW(dcf_pkg::DATA_W)) mem_bus ();

    dcf_mem #(.AW(AW), .DW(dcf_pkg::DATA_W)) u_mem (
        .i_wr_clk (I_CLK),
        .i_rd_clk (I_RD_CLK),
        .m        (mem_bus)
    );

    // ==========================================================
    // APB slave, write-clock domain; no wait states, PREADY is high in the first access cycle
    always_comb begin
        rd_word = '0;
        if (I_PADDR == dcf_pkg::REG_CTRL_ADDR) begin
            rd_word[dcf_pkg::CTRL_CASCADE_BIT] = cascade_reg;
        end else if (I_PADDR == dcf_pkg::REG_STATUS_ADDR) begin
            rd_word[dcf_pkg::STAT_FULL_N_BIT]  = full_n_reg;
            rd_word[dcf_pkg::STAT_SHARED_BIT]  = shared_reg;
            rd_word[dcf_pkg::STAT_AFULL_N_BIT] = afull_n_reg;
            rd_word[dcf_pkg::STAT_TOKEN_BIT]   = wr_token_reg;
            rd_word[dcf_pkg::STAT_COUNT_LSB +: PTR_W] = count_w_reg;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= I_PSEL && !I_PENABLE;
            pslverr_reg <= I_PSEL && !I_PENABLE && !reg_hit(I_PADDR);
            prdata_reg  <= (I_PSEL && !I_PENABLE && !I_PWRITE) ? rd_word : '0;
        end
    end

    // Cascade mode steers the shared pin and gates both ports
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            cascade_reg <= 1'b0;
        end else if (I_PSEL && I_PENABLE && pready_reg && I_PWRITE
                     && I_PADDR == dcf_pkg::REG_CTRL_ADDR) begin
            cascade_reg <= I_PWDATA[dcf_pkg::CTRL_CASCADE_BIT]; // R13
        end
    end

    // ==========================================================
    // Write domain
    assign do_write     = !I_WR_EN_N && full_n_reg && (!cascade_reg || wr_token_reg); // R16
    assign wr_bin_next  = wr_bin_reg + PTR_W'(do_write); // R3
    assign wr_gray_next = to_gray(wr_bin_next);
    assign count_w_next = wr_bin_next - to_bin(rgs_reg);
    assign full_next    = wr_gray_next == {~rgs_reg[PTR_W-1:PTR_W-2], rgs_reg[PTR_W-3:0]};
    assign wr_fire      = cascade_reg && do_write && full_next;
    // Strap low picks the settled count, high the count after this edge
    assign af_count     = I_SYNC_FLAG_SEL_N ? count_w_next : count_w_reg; // R10

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            wr_bin_reg  <= '0;
            wr_gray_reg <= '0;
            count_w_reg <= '0;
        end else begin
            wr_bin_reg  <= wr_bin_next; // R6
            wr_gray_reg <= wr_gray_next; // R5
            count_w_reg <= count_w_next;
        end
    end

    // Read pointer into write domain; gray code keeps the sample coherent
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            rgs_meta_reg <= '0;
            rgs_reg      <= '0;
        end else begin
            rgs_meta_reg <= rd_gray_reg; // R5
            rgs_reg      <= rgs_meta_reg;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            full_n_reg  <= 1'b1;
            afull_n_reg <= 1'b1;
            shared_reg  <= 1'b1;
        end else begin
            full_n_reg  <= !full_next; // R8 R9 R19
            afull_n_reg <= !(af_count >= AF_LVL); // R11
            shared_reg  <= cascade_reg ? !wr_fire : !(count_w_next > HALF_LVL); // R12 R13 R20
        end
    end

    // Write token: incoming handoff wins over our own release
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            wr_token_reg <= !I_FIRST_IN_CHAIN_N; // R15
        end else if (!I_WR_CHAIN_IN_N) begin
            wr_token_reg <= 1'b1; // R14
        end else if (wr_fire) begin
            wr_token_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Read domain; its reset is the write reset brought over
    always_ff @(posedge I_RD_CLK) begin
        rst_meta_reg  <= I_RST;
        rst_rd_reg    <= rst_meta_reg;
        casc_meta_reg <= cascade_reg;
        casc_rd_reg   <= casc_meta_reg;
    end

    always_ff @(posedge I_RD_CLK) begin
        if (rst_rd_reg) begin
            wgs_meta_reg <= '0;
            wgs_reg      <= '0;
        end else begin
            wgs_meta_reg <= wr_gray_reg; // R5
            wgs_reg      <= wgs_meta_reg;
        end
    end

    assign do_read      = !I_RD_EN_N && empty_n_reg && (!casc_rd_reg || rd_token_reg); // R17
    assign rd_bin_next  = rd_bin_reg + PTR_W'(do_read); // R4
    assign rd_gray_next = to_gray(rd_bin_next);
    assign count_r_next = to_bin(wgs_reg) - rd_bin_next;
    assign empty_next   = rd_gray_next == wgs_reg;
    assign rd_fire      = casc_rd_reg && do_read && empty_next;
    assign ae_count     = I_SYNC_FLAG_SEL_N ? count_r_next : count_r_reg; // R10

    always_ff @(posedge I_RD_CLK) begin
        if (rst_rd_reg) begin
            rd_bin_reg  <= '0;
            rd_gray_reg <= '0;
            count_r_reg <= '0;
        end else begin
            rd_bin_reg  <= rd_bin_next; // R6
            rd_gray_reg <= rd_gray_next;
            count_r_reg <= count_r_next;
        end
    end

    always_ff @(posedge I_RD_CLK) begin
        if (rst_rd_reg) begin
            empty_n_reg  <= 1'b0;
            aempty_n_reg <= 1'b0;
            rd_chain_reg <= 1'b1;
        end else begin
            empty_n_reg  <= !empty_next; // R7 R9 R18
            aempty_n_reg <= !(ae_count <= AE_LVL); // R11
            rd_chain_reg <= !rd_fire;
        end
    end

    always_ff @(posedge I_RD_CLK) begin
        if (rst_rd_reg) begin
            rd_token_reg <= !I_FIRST_IN_CHAIN_N; // R15
        end else if (!I_RD_CHAIN_IN_N) begin
            rd_token_reg <= 1'b1; // R14
        end else if (rd_fire) begin
            rd_token_reg <= 1'b0;
        end
    end

    // Enable is sampled on the read clock, not a true three-state release
    always_ff @(posedge I_RD_CLK) begin
        if (rst_rd_reg) begin
            data_out_reg <= dcf_pkg::OUT_IDLE;
        end else begin
            data_out_reg <= I_OUT_EN_N ? dcf_pkg::OUT_IDLE : mem_bus.rd_data; // R21 R2
        end
    end

    // ==========================================================
    // Memory hookup and outputs
    assign mem_bus.wr_en   = do_write;
    assign mem_bus.wr_addr = wr_bin_reg[AW-1:0];
    assign mem_bus.wr_data = I_DATA;
    assign mem_bus.rd_en   = do_read;
    assign mem_bus.rd_addr = rd_bin_reg[AW-1:0];

    assign O_DATA            = data_out_reg;
    assign O_EMPTY_N         = empty_n_reg;
    assign O_FULL_N          = full_n_reg;
    assign O_ALMOST_EMPTY_N  = aempty_n_reg;
    assign O_ALMOST_FULL_N   = afull_n_reg;
    assign O_HALF_WR_CHAIN_N = shared_reg;
    assign O_RD_CHAIN_OUT_N  = rd_chain_reg;
    assign O_PRDATA          = prdata_reg;
    assign O_PREADY          = pready_reg;
    assign O_PSLVERR         = pslverr_reg;

    // ==========================================================
    // Checks
    property p_write_step; // R3
        @(posedge I_CLK) disable iff (I_RST)
        do_write |=> (wr_bin_reg == $past(wr_bin_reg) + PTR_W'(1));
    endproperty
    a_write_step: assert property (p_write_step) else $error("write did not advance pointer");

    property p_full_blocks; // R16
        @(posedge I_CLK) disable iff (I_RST)
        (!I_WR_EN_N && !full_n_reg) |=> $stable(wr_bin_reg);
    endproperty
    a_full_blocks: assert property (p_full_blocks) else $error("write accepted while full");

    property p_empty_blocks; // R17
        @(posedge I_RD_CLK) disable iff (rst_rd_reg)
        (!I_RD_EN_N && !empty_n_reg) |=> $stable(rd_bin_reg);
    endproperty
    a_empty_blocks: assert property (p_empty_blocks) else $error("read accepted while empty");

    property p_read_step; // R4
        @(posedge I_RD_CLK) disable iff (rst_rd_reg)
        do_read |=> (rd_bin_reg == $past(rd_bin_reg) + PTR_W'(1));
    endproperty
    a_read_step: assert property (p_read_step) else $error("read did not advance pointer");

    property p_gray_one_bit; // R5
        @(posedge I_CLK) disable iff (I_RST)
        ##1 $onehot0(wr_gray_reg ^ $past(wr_gray_reg));
    endproperty
    a_gray_one_bit: assert property (p_gray_one_bit) else $error("write gray moved two bits");

    property p_empty_seen; // R18
        @(posedge I_RD_CLK) disable iff (rst_rd_reg)
        (rd_gray_reg == wgs_reg && !do_read) |=> !empty_n_reg;
    endproperty
    a_empty_seen: assert property (p_empty_seen) else $error("empty flag missed");

    property p_full_seen; // R19
        @(posedge I_CLK) disable iff (I_RST)
        (count_w_reg == PTR_W'(DEPTH) && rgs_reg == $past(rgs_reg)) |=> !full_n_reg;
    endproperty
    a_full_seen: assert property (p_full_seen) else $error("full flag missed");

    property p_half_level; // R20
        @(posedge I_CLK) disable iff (I_RST)
        !cascade_reg |=> (shared_reg == (count_w_reg <= HALF_LVL));
    endproperty
    a_half_level: assert property (p_half_level) else $error("half flag wrong");

    property p_af_sync; // R10
        @(posedge I_CLK) disable iff (I_RST)
        !I_SYNC_FLAG_SEL_N |=> (afull_n_reg == ($past(count_w_reg) < AF_LVL));
    endproperty
    a_af_sync: assert property (p_af_sync) else $error("registered almost full wrong");

    property p_chain_pulse; // R13
        @(posedge I_CLK) disable iff (I_RST)
        (cascade_reg && !shared_reg) |=> shared_reg;
    endproperty
    a_chain_pulse: assert property (p_chain_pulse) else $error("chain handoff too long");

    property p_out_idle; // R21
        @(posedge I_RD_CLK) disable iff (rst_rd_reg)
        I_OUT_EN_N |=> (O_DATA == dcf_pkg::OUT_IDLE);
    endproperty
    a_out_idle: assert property (p_out_idle) else $error("data driven while disabled");
endmodule

// *** verification/dcf_reader_model.sv ***
// Reader-side model of the logic beside the FIFO output port.
// Assumes its own free-running read clock, unrelated in phase to the write clock.
`timescale 1ns/1ns

module dcf_reader_model (
    output logic                       o_rd_clk,
    output logic                       o_rd_en_n,
    output logic                       o_out_en_n,
    input  wire logic [dcf_pkg::DATA_W-1:0] i_data,
    input  wire logic                  i_empty_n
);
    // ==========================================================
    // Read clock, period 12 ns so reset spans four of its edges
    initial begin
        o_rd_clk   = 1'b0;
        o_rd_en_n  = 1'b1;
        o_out_en_n = 1'b0;
        forever #6 o_rd_clk = ~o_rd_clk;
    end

    // ==========================================================
    // One read; honour_empty=0 reads blindly to probe refusal
    task automatic pop(input bit honour_empty, output logic [dcf_pkg::DATA_W-1:0] w);
        @(posedge o_rd_clk);
        while (honour_empty && i_empty_n !== 1'b1) begin
            @(posedge o_rd_clk);
        end
        o_rd_en_n <= 1'b0;
        @(posedge o_rd_clk);
        o_rd_en_n <= 1'b1;
        @(posedge o_rd_clk);
        #1 w = i_data;
    endtask

    task automatic set_oe_n(input logic v);
        @(posedge o_rd_clk);
        o_out_en_n <= v;
        repeat (2) @(posedge o_rd_clk);
        #1;
    endtask
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the dual-clock FIFO: writer, APB master and checks.
// Assumes the reader model supplies the read clock and read-side controls.
`timescale 1ns/1ns

module testbench;
    logic                          clk;
    logic                          rst;
    logic                          wr_en_n;
    logic [dcf_pkg::DATA_W-1:0]    wdata;
    logic                          psel;
    logic                          penable;
    logic                          pwrite;
    logic [dcf_pkg::APB_ADDR_W-1:0] paddr;
    logic [dcf_pkg::APB_DATA_W-1:0] pwdata;
    wire logic                     rd_clk;
    wire logic                     rd_en_n;
    wire logic                     oe_n;
    logic [dcf_pkg::DATA_W-1:0]    rdata;
    logic                          empty_n;
    logic                          full_n;
    logic                          aempty_n;
    logic                          afull_n;
    logic                          half_n;
    logic [dcf_pkg::APB_DATA_W-1:0] prdata;
    logic                          pready;
    logic                          pslverr;
    logic                          sync_sel_n;
    wire logic                     rd_chain_n;
    int                            err_total = 0;
    int                            checked = 0;
    int                            cycles = 0;

    dcf_fifo #(.DEPTH(256), .AE_OFFSET(8), .AF_OFFSET(8)) uut (
        .I_CLK(clk), .I_RST(rst), .I_RD_CLK(rd_clk), .I_WR_EN_N(wr_en_n),
        .I_DATA(wdata), .I_RD_EN_N(rd_en_n), .I_OUT_EN_N(oe_n),
        .I_SYNC_FLAG_SEL_N(sync_sel_n), .I_FIRST_IN_CHAIN_N(1'b0),
        .I_WR_CHAIN_IN_N(half_n), .I_RD_CHAIN_IN_N(rd_chain_n),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_DATA(rdata), .O_EMPTY_N(empty_n), .O_FULL_N(full_n),
        .O_ALMOST_EMPTY_N(aempty_n), .O_ALMOST_FULL_N(afull_n),
        .O_HALF_WR_CHAIN_N(half_n), .O_RD_CHAIN_OUT_N(rd_chain_n), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr));

    dcf_reader_model u_reader (
        .o_rd_clk(rd_clk), .o_rd_en_n(rd_en_n), .o_out_en_n(oe_n),
        .i_data(rdata), .i_empty_n(empty_n));

    // ==========================================================
    // Clock and hang guard, ceiling well above the roughly 4000 cycles used
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    // ==========================================================
    // Compare and report
    task automatic chk_flag(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Bus and port drivers
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Enable stays low across the burst: every edge stores one word until the buffer is full
    task automatic wr_words(input logic [17:0] base, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            wr_en_n <= 1'b0;
            wdata   <= base + 18'(i);
        end
        @(posedge clk);
        wr_en_n <= 1'b1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk_flag(empty_n, 1'b0);
        chk_flag(full_n, 1'b1);
        chk_flag(half_n, 1'b1);
        chk_flag(aempty_n, 1'b0);
        chk_flag(afull_n, 1'b1);
        chk_flag(rd_chain_n, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_regs();
        logic [31:0] rd;
        logic        e;
        apb(1'b0, dcf_pkg::REG_CTRL_ADDR, 32'h0, rd, e);
        chk_val(rd, 32'h0);
        apb(1'b1, dcf_pkg::REG_CTRL_ADDR, 32'h1, rd, e);
        apb(1'b0, dcf_pkg::REG_CTRL_ADDR, 32'h0, rd, e);
        chk_val(rd, 32'h1);
        apb(1'b1, dcf_pkg::REG_CTRL_ADDR, 32'h0, rd, e);
        apb(1'b1, dcf_pkg::REG_STATUS_ADDR, 32'hffffffff, rd, e);
        chk_flag(e, 1'b0);
        apb(1'b0, dcf_pkg::REG_STATUS_ADDR, 32'h0, rd, e);
        chk_val({rd[31:16], 12'h0, rd[3:0]}, 32'hf);
        apb(1'b0, 8'h08, 32'h0, rd, e);
        chk_flag(e, 1'b1);
        $display("test regs done");
    endtask

    // Writer and reader run at once on unrelated clocks
    task automatic t_order();
        logic [17:0] w;
        fork
            wr_words(18'h3a5c0, 6);
            for (int i = 0; i < 6; i++) begin
                u_reader.pop(1'b1, w);
                chk_val(32'(w), 32'(18'h3a5c0 + 18'(i)));
            end
        join
        $display("test order done");
    endtask

    // Blind read on an empty buffer must leave output and flags alone
    task automatic t_empty_read();
        logic [17:0] w;
        u_reader.pop(1'b0, w);
        chk_val(32'(w), 32'(18'h3a5c5));
        chk_flag(empty_n, 1'b0);
        chk_flag(aempty_n, 1'b0);
        $display("test empty read done");
    endtask

    task automatic t_full();
        logic [31:0] rd;
        logic [17:0] w;
        logic        e;
        wr_words(18'h10000, 257);
        repeat (2) @(posedge clk);
        #1;
        chk_flag(full_n, 1'b0);
        chk_flag(half_n, 1'b0);
        chk_flag(afull_n, 1'b0);
        apb(1'b0, dcf_pkg::REG_STATUS_ADDR, 32'h0, rd, e);
        chk_val(32'(rd[24:16]), 32'h100);
        chk_flag(rd[0], 1'b0);
        repeat (20) @(posedge clk);
        chk_flag(empty_n, 1'b1);
        chk_flag(aempty_n, 1'b1);
        for (int i = 0; i < 256; i++) begin
            u_reader.pop(1'b1, w);
            chk_val(32'(w), 32'(18'h10000 + 18'(i)));
        end
        repeat (20) @(posedge clk);
        #1;
        chk_flag(empty_n, 1'b0);
        chk_flag(full_n, 1'b1);
        chk_flag(half_n, 1'b1);
        chk_flag(afull_n, 1'b1);
        $display("test full done");
    endtask

    // Ring of one: the fill handoff comes straight back as our own token
    task automatic t_cascade();
        logic [31:0] rd;
        logic [17:0] w;
        logic        e;
        apb(1'b1, dcf_pkg::REG_CTRL_ADDR, 32'h1, rd, e);
        wr_words(18'h0c0de, 257);
        repeat (4) @(posedge clk);
        #1;
        chk_flag(full_n, 1'b0);
        chk_flag(half_n, 1'b1);
        apb(1'b0, dcf_pkg::REG_STATUS_ADDR, 32'h0, rd, e);
        chk_flag(rd[3], 1'b1);
        for (int i = 0; i < 256; i++) begin
            u_reader.pop(1'b1, w);
            chk_val(32'(w), 32'(18'h0c0de + 18'(i)));
        end
        chk_flag(rd_chain_n, 1'b1);
        apb(1'b1, dcf_pkg::REG_CTRL_ADDR, 32'h0, rd, e);
        $display("test cascade done");
    endtask

    task automatic t_oe();
        logic [17:0] w;
        wr_words(18'h2b3c4, 1);
        u_reader.pop(1'b1, w);
        chk_val(32'(w), 32'(18'h2b3c4));
        u_reader.set_oe_n(1'b1);
        chk_val(32'(rdata), 32'(dcf_pkg::OUT_IDLE));
        u_reader.set_oe_n(1'b0);
        $display("test output enable done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rst     = 1'b1;
        wr_en_n = 1'b1;
        wdata   = 18'h00000;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        sync_sel_n = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_regs();
        t_order();
        t_empty_read();
        t_full();
        t_cascade();
        @(posedge clk);
        sync_sel_n <= 1'b1;
        t_full();
        t_oe();
        end_of_test();
    end
endmodule
